// ===== include/spi_pkg.sv
// constants shared by the serial register access slave
// assumes a single 250 MHz system clock and a host-driven serial link
//
// What this block does
// RULE_01 - device is slave only, never drives clock
// RULE_02 - datagrams are 40 bits, at most 2 Mbit/s
// RULE_03 - bits travel msb first, bit 39 to 0
// RULE_04 - bit 39 is the direction flag
// RULE_05 - bits 38 to 32 give register address
// RULE_06 - bits 31 to 0 carry register data
// RULE_07 - answer returned within the same datagram
// RULE_08 - input sampled on rising serial clock edge
// RULE_09 - output bit updated after falling clock edge
// RULE_10 - flag zero reads, flag one writes
// RULE_11 - writes to read-only registers are dropped
// RULE_12 - select frames datagram; write only after 40 bits

`default_nettype none

// ==========================================================
// package
package spi_pkg;
    localparam int DGRAM_BITS = 40;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int REG_COUNT = 128;
    localparam int CNT_W = 6;
    localparam logic [5:0] FLAG_POS = 6'h27;      // bit 39
    localparam logic [5:0] HDR_LAST = 6'h07;      // count before 8th bit
    localparam logic [5:0] DATA_FIRST = 6'h08;
    localparam logic [5:0] LAST_IDX = 6'h27;      // 39
    localparam logic [5:0] FULL_CNT = 6'h28;      // 40 bits
    localparam logic [5:0] OVER_CNT = 6'h29;      // overlong marker
    localparam logic FLAG_WRITE = 1'b1;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    // timing
    localparam int SYS_CLK_PS = 4000;
    localparam int T_SCK_HALF_NS = 250;           // least high or low time
    localparam int SCK_HALF_CYC = (T_SCK_HALF_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
    localparam int RD_LAT = 2;                    // core read latency in cycles
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HDR = 3'b010,
        ST_DATA = 3'b100
    } frame_state_t;
endpackage
`default_nettype wire

// ===== hw/pin_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes the inputs are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// synchroniser
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] rst_val,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            sync_out <= '1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

    logic unused_rst_val;
    assign unused_rst_val = ^rst_val;
endmodule
`default_nettype wire

// ===== hw/spi_register_access_slave.sv
// serial register access slave: 40-bit datagrams framed by select
// assumes the core answers rd_data a fixed RD_LAT cycles after rd_req
`timescale 1ns/10ps
`default_nettype none

module spi_register_access_slave (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic chip_select_low,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic rd_req,
    output logic [6:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic [127:0] read_only_map,
    output logic wr_en,
    output logic [6:0] wr_addr,
    output logic [31:0] wr_data
);
    // ==========================================================
    // reset release
    logic rst_m_q;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_m_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n <= rst_m_q;
        end
    end

    // ==========================================================
    // pin synchronisers and edge detection
    logic [2:0] pins_s;
    logic sck_s;
    logic cs_s;
    logic mosi_s;
    logic sck_d_q;
    logic cs_d_q;

    // serial clock is only sampled, never driven here  RULE_01
    pin_sync #(.WIDTH(3)) u_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .rst_val(3'b111),
        .async_in({sclk, chip_select_low, mosi}),
        .sync_out(pins_s)
    );
    assign sck_s = pins_s[2];
    assign cs_s = pins_s[1];
    assign mosi_s = pins_s[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_d_q <= 1'b1;                            // matches synchroniser reset, no false edge
            cs_d_q <= 1'b1;
        end else begin
            sck_d_q <= sck_s;
            cs_d_q <= cs_s;
        end
    end

    logic cs_act;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    assign cs_act = ~cs_s;
    assign cs_fall = cs_d_q & ~cs_s;
    assign cs_rise = ~cs_d_q & cs_s;
    assign sck_rise = cs_act & sck_s & ~sck_d_q;   // RULE_08
    assign sck_fall = cs_act & ~sck_s & sck_d_q;

    // ==========================================================
    // frame state
    spi_pkg::frame_state_t state_q;
    logic [5:0] cnt_q;

    // select low opens a frame, high closes it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= spi_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                spi_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        state_q <= spi_pkg::ST_HDR;
                    end
                end
                spi_pkg::ST_HDR: begin
                    if (cs_rise) begin
                        state_q <= spi_pkg::ST_IDLE;
                    end else if (sck_rise && cnt_q == spi_pkg::HDR_LAST) begin
                        state_q <= spi_pkg::ST_DATA;
                    end
                end
                spi_pkg::ST_DATA: begin
                    if (cs_rise) begin
                        state_q <= spi_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= spi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // bit counter; saturates so an overlong frame is recognisable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (cs_fall) begin
            cnt_q <= '0;                                // RULE_12
        end else if (sck_rise && cnt_q != spi_pkg::OVER_CNT) begin
            cnt_q <= cnt_q + 6'h01;                     // RULE_02
        end
    end

    // ==========================================================
    // receive shift register, msb arrives first
    logic [39:0] rx_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q <= '0;
        end else if (cs_fall) begin
            rx_q <= '0;
        end else if (sck_rise) begin
            rx_q <= {rx_q[38:0], mosi_s};               // RULE_03
        end
    end

    // ==========================================================
    // register fetch once the header is in
    logic hdr_evt;
    logic [spi_pkg::RD_LAT-1:0] lat_q;
    logic [31:0] tx_q;
    logic dir_q;

    assign hdr_evt = sck_rise && cnt_q == spi_pkg::HDR_LAST;

    // both directions fetch, so a write answers with the old contents
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_req <= 1'b0;
            rd_addr <= '0;
            dir_q <= 1'b0;
        end else begin
            rd_req <= hdr_evt;                          // RULE_07
            if (hdr_evt) begin
                rd_addr <= {rx_q[5:0], mosi_s};         // RULE_05
                dir_q <= rx_q[6];                       // RULE_04
            end
        end
    end

    // read data is captured a fixed latency after the request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_q <= '0;
            tx_q <= spi_pkg::DATA_RST;
        end else begin
            lat_q <= {lat_q[spi_pkg::RD_LAT-2:0], rd_req};
            if (cs_fall) begin
                tx_q <= spi_pkg::DATA_RST;
            end else if (lat_q[spi_pkg::RD_LAT-1]) begin
                tx_q <= rd_data;                        // RULE_06
            end
        end
    end

    // ==========================================================
    // serial output: header slots are zero, then 32 data bits
    logic [5:0] out_idx;
    assign out_idx = spi_pkg::LAST_IDX - cnt_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            miso <= 1'b0;
        end else if (cs_fall) begin
            miso <= 1'b0;
        end else if (sck_fall) begin
            if (cnt_q >= spi_pkg::DATA_FIRST && cnt_q <= spi_pkg::LAST_IDX) begin
                miso <= tx_q[out_idx[4:0]];             // RULE_09
            end else begin
                miso <= 1'b0;
            end
        end
    end

    // line is released while deselected so other slaves may share it
    assign miso_oe = cs_act;

    // ==========================================================
    // write commit at the end of a full frame
    logic wr_ok;
    assign wr_ok = cs_rise && cnt_q == spi_pkg::FULL_CNT
        && rx_q[spi_pkg::FLAG_POS] == spi_pkg::FLAG_WRITE            // RULE_10
        && !read_only_map[rx_q[38:32]];                               // RULE_11

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en <= 1'b0;
            wr_addr <= '0;
            wr_data <= spi_pkg::DATA_RST;
        end else begin
            wr_en <= wr_ok;                             // RULE_12
            if (wr_ok) begin
                wr_addr <= rx_q[38:32];
                wr_data <= rx_q[31:0];
            end
        end
    end

    // ==========================================================
    // assertions
    sequence s_hdr_done;
        hdr_evt;
    endsequence

    sequence s_load;
        ##1 rd_req ##2 lat_q[1];
    endsequence

    a_oe_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
        miso_oe |-> cs_fall || state_q != spi_pkg::ST_IDLE) else $error("output driven outside frame"); // RULE_01
    a_cnt_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cs_fall |=> cnt_q == 6'h00) else $error("counter not cleared"); // RULE_12
    a_cnt_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sck_rise && !cs_fall && cnt_q < spi_pkg::OVER_CNT |=> cnt_q == $past(cnt_q) + 6'h01)
        else $error("counter missed a bit"); // RULE_02
    a_shift_in: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sck_rise && !cs_fall |=> rx_q[0] == $past(mosi_s) && rx_q[39:1] == $past(rx_q[38:0]))
        else $error("bad shift"); // RULE_03
    a_fetch_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_hdr_done |-> s_load) else $error("fetch pipeline broken"); // RULE_07
    a_hdr_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_req |-> rd_addr == rx_q[6:0] && dir_q == rx_q[7]) else $error("header decode wrong"); // RULE_05
    a_write_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en |-> $past(rx_q[39]) && $past(cnt_q) == spi_pkg::FULL_CNT) else $error("bad write"); // RULE_10
    a_write_ro: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en |-> !$past(read_only_map[rx_q[38:32]])) else $error("read-only written"); // RULE_11
    a_write_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en |-> wr_data == $past(rx_q[31:0]) && wr_addr == $past(rx_q[38:32]))
        else $error("write fields wrong"); // RULE_06
    a_miso_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(miso) |-> $past(sck_fall) || $past(cs_fall)) else $error("output moved off edge"); // RULE_09
    a_write_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en |-> $past(cs_rise)) else $error("write before select rose"); // RULE_12
    a_sample_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(cnt_q) && cnt_q != 6'h00 |-> $past(sck_s) && !$past(sck_d_q))
        else $error("sample off rising edge"); // RULE_08
    a_dir_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en |-> $past(dir_q) == spi_pkg::FLAG_WRITE) else $error("flag lost"); // RULE_04
endmodule
`default_nettype wire

// ===== bench/spi_host_model.sv
// application controller model: serial bus master that frames and shifts datagrams
// assumes sys_clk is the bench clock; timing is counted in its cycles
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// host model
module spi_host_model #(
    parameter int HALF = 63
) (
    input wire logic sys_clk,
    output logic sclk,
    output logic chip_select_low,
    output logic mosi,
    input wire logic miso
);
    // clock idles low and stands still outside frames
    initial begin
        sclk = 1'b0;
        chip_select_low = 1'b1;
        mosi = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // shifts tx[nbits-1:0] msb first; rx holds what was captured at each rise
    task automatic xfer(input logic [40:0] tx, input int nbits, output logic [40:0] rx);
        rx = '0;
        chip_select_low <= 1'b0;
        wait_cyc(HALF);
        for (int i = nbits - 1; i >= 0; i--) begin
            mosi <= tx[i];
            wait_cyc(HALF);
            sclk <= 1'b1;
            rx[i] = miso;
            wait_cyc(HALF);
            sclk <= 1'b0;
            wait_cyc(HALF);
        end
        chip_select_low <= 1'b1;
        // released data line must not keep showing the last bit
        mosi <= ~mosi;
        wait_cyc(HALF);
    endtask
endmodule
`default_nettype wire

// ===== bench/spi_register_access_slave_test.sv
// self-checking bench for the serial register access slave
// assumes a host model on the link and a two-cycle register core built here
`timescale 1ns/10ps
`default_nettype none

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end

module spi_register_access_slave_test;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] rd_data = 32'h0000_0000;
    logic [127:0] read_only_map = 128'h0000_0020;
    wire sclk, chip_select_low, mosi, miso, miso_oe, rd_req, wr_en;
    wire [6:0] rd_addr, wr_addr;
    wire [31:0] wr_data;
    logic [31:0] mem [128];
    logic rd_p1 = 1'b0;
    int wr_cnt = 0;
    int error_cnt = 0;
    int checks = 0;

    // ==========================================================
    // clock, instances
    always #2 sys_clk = ~sys_clk;

    spi_host_model #(.HALF(63)) host (.sys_clk(sys_clk), .sclk(sclk), .chip_select_low(chip_select_low),
        .mosi(mosi), .miso(miso));

    spi_register_access_slave dut (.sys_clk(sys_clk), .nrst(nrst), .sclk(sclk),
        .chip_select_low(chip_select_low), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .read_only_map(read_only_map),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

    // ==========================================================
    // register core: answer valid for two cycles, garbage otherwise
    initial for (int i = 0; i < 128; i++) mem[i] = {4{1'b0, 7'(i)}};
    always @(posedge sys_clk) begin
        rd_p1 <= rd_req;
        rd_data <= (rd_req || rd_p1) ? mem[rd_addr] : ~rd_data;
        if (wr_en === 1'b1) begin
            mem[wr_addr] <= wr_data;
            wr_cnt <= wr_cnt + 1;
        end
    end

    // one datagram: flag, address, data; returns the 40 bits seen on miso
    task automatic frame(input logic flag, input logic [6:0] a, input logic [31:0] d, output logic [39:0] back);
        logic [40:0] rx;
        host.xfer({1'b0, flag, a, d}, 40, rx);
        back = rx[39:0];
    endtask

    // ==========================================================
    // scenarios
    task automatic s_bad_len();
        logic [40:0] rx;
        int w0;
        w0 = wr_cnt;
        host.xfer({3'b001, 7'h02, 31'h1234_5678}, 39, rx);
        `CHK("short frame writes", w0, wr_cnt)
        host.xfer({1'b1, 7'h02, 32'h1234_5678, 1'b0}, 41, rx);
        `CHK("long frame writes", w0, wr_cnt)
        `CHK("reg 2 kept", {4{8'h02}}, mem[2])
    endtask

    task automatic s_write_read();
        logic [39:0] b;
        int w0;
        w0 = wr_cnt;
        `CHK("idle oe", 1'b0, miso_oe)
        fork
            frame(1'b1, 7'h01, 32'h2345_6789, b);
            begin host.wait_cyc(500); `CHK("frame oe", 1'b1, miso_oe) end
        join
        `CHK("wr header out", 8'h00, b[39:32])
        `CHK("wr returns old", {4{8'h01}}, b[31:0])
        `CHK("wr count", w0 + 1, wr_cnt)
        `CHK("wr addr", 7'h01, wr_addr)
        `CHK("wr data", 32'h2345_6789, wr_data)
        frame(1'b0, 7'h01, 32'hffff_ffff, b);
        `CHK("rd data", 40'h00_2345_6789, b)
        `CHK("rd no write", w0 + 1, wr_cnt)
        frame(1'b1, 7'h7f, 32'ha5a5_5a5a, b);
        `CHK("top addr", 7'h7f, wr_addr)
        `CHK("top data", 32'ha5a5_5a5a, mem[127])
        `CHK("idle oe after", 1'b0, miso_oe)
    endtask

    task automatic s_read_only();
        logic [39:0] b;
        int w0;
        w0 = wr_cnt;
        frame(1'b1, 7'h05, 32'hdead_beef, b);
        `CHK("ro write dropped", w0, wr_cnt)
        frame(1'b0, 7'h05, 32'h0000_0000, b);
        `CHK("ro value kept", {8'h00, {4{8'h05}}}, b)
        frame(1'b1, 7'h06, 32'h0bad_cafe, b);
        `CHK("rw neighbour", 32'h0bad_cafe, mem[6])
    endtask

    // ==========================================================
    // run control
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // eight frames of about 7700 cycles each take some 62k cycles; stop at 80k
    initial begin
        #320000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        s_bad_len();
        s_write_read();
        s_read_only();
        report_and_stop();
    end
endmodule
`default_nettype wire
